// ---- verilog/prom_host_regs.svh ----
// Purpose: constants for the rewriteable prom host controller
// Assumes: 50 MHz system clock
// Notes:   command addresses and data are hexadecimal
`ifndef PROM_HOST_REGS_SVH
`define PROM_HOST_REGS_SVH

`define UNLOCK_ADDR_A      16'h5555
`define UNLOCK_ADDR_B      16'h2aaa
`define UNLOCK_DATA_A      8'haa
`define UNLOCK_DATA_B      8'h55
`define CMD_ERASE_SETUP    8'h80
`define CMD_ERASE_CONFIRM  8'h10
`define CMD_PROGRAM_SETUP  8'ha0
`define CMD_ID_ENTRY       8'h90
`define CMD_ID_EXIT        8'hf0
`define ERASED_WORD        16'hffff
`define ID_MFR_ADDR        16'h0000
`define ID_DEV_ADDR        16'h0001

`define CLK_PERIOD_NS      20
// strobe low, setup and recovery: 60 ns, well above the 15 ns glitch filter
`define STROBE_NS          60
`define STROBE_CYC         ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// read access settle: 100 ns
`define READ_NS            100
`define READ_CYC           ((`READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// word program wait, typical 20 us, doubled margin
`define WORD_PROGRAM_TIME_US 40
`define WORD_PROGRAM_CYC   ((`WORD_PROGRAM_TIME_US * 1000) / `CLK_PERIOD_NS)
// chip erase at most 0.5 s
`define ERASE_TIME_MS      500
`define ERASE_CYC          ((`ERASE_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ---- verilog/prom_host_pkg.sv ----
// Purpose: types for the rewriteable prom host controller
// Assumes: nothing
// Notes:   pin group travels as one struct
package prom_host_pkg;

	typedef enum logic [2:0] {
		OP_READ    = 3'h0,
		OP_ERASE   = 3'h1,
		OP_PROGRAM = 3'h2,
		OP_ID_ENTRY = 3'h3,
		OP_ID_EXIT = 3'h4
	} op_t;

	typedef struct packed {
		logic        chip_en_n;
		logic        out_en_n;
		logic        write_en_n;
		logic [15:0] word_address_in;
		logic [15:0] data_out;
		logic        data_oe;
	} pin_bus_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} bus_cycle_t;

endpackage : prom_host_pkg

// ---- verilog/prom_write_cycle.sv ----
// Purpose: one write bus cycle on the prom pins
// Assumes: strobe widths set from STROBE_CYC
// Notes:   address set before the write strobe falls, data held past its rise
`timescale 1ns/1ps
`include "prom_host_regs.svh"
module prom_write_cycle
	import prom_host_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	input  wire logic       start_i,
	input  wire bus_cycle_t cycle_i,
	output logic            busy_o,
	output logic            done_o,
	output pin_bus_t        pins_o
);
	typedef enum logic [3:0] {
		WC_IDLE  = 4'b0001,
		WC_SETUP = 4'b0010,
		WC_LOW   = 4'b0100,
		WC_HOLD  = 4'b1000
	} wc_state_t;

	localparam logic [7:0] STROBE_CNT = 8'(`STROBE_CYC);

	wc_state_t  state_r, state_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	bus_cycle_t cyc_r, cyc_nxt;
	pin_bus_t   pins_r, pins_nxt;
	logic       done_r, done_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		cyc_nxt   = cyc_r;
		done_nxt  = 1'b0;
		pins_nxt  = pins_r;
		unique case (state_r)
			WC_IDLE: begin
				if (start_i) begin
					cyc_nxt  = cycle_i;
					pins_nxt = '{chip_en_n: 1'b0, out_en_n: 1'b1, write_en_n: 1'b1,
						word_address_in: cycle_i.addr, data_out: cycle_i.data, data_oe: 1'b1};
					cnt_nxt   = STROBE_CNT;
					state_nxt = WC_SETUP;
				end
			end
			WC_SETUP: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					// strobe low far longer than the glitch filter
					pins_nxt.write_en_n = 1'b0;
					cnt_nxt   = STROBE_CNT;
					state_nxt = WC_LOW;
				end
			end
			WC_LOW: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					pins_nxt.write_en_n = 1'b1;
					cnt_nxt   = STROBE_CNT;
					state_nxt = WC_HOLD;
				end
			end
			WC_HOLD: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					pins_nxt.chip_en_n = 1'b1;
					pins_nxt.data_oe   = 1'b0;
					done_nxt  = 1'b1;
					state_nxt = WC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_r <= WC_IDLE;
			cnt_r   <= 8'h00;
			cyc_r   <= '0;
			done_r  <= 1'b0;
			pins_r  <= '{chip_en_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1,
				word_address_in: 16'h0000, data_out: 16'h0000, data_oe: 1'b0};
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			cyc_r   <= cyc_nxt;
			done_r  <= done_nxt;
			pins_r  <= pins_nxt;
		end
	end

	assign busy_o = (state_r != WC_IDLE);
	assign done_o = done_r;
	assign pins_o = pins_r;

	// output enable never low while write strobe is low
	a_we_oe_excl: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!pins_r.write_en_n |-> (pins_r.out_en_n && !pins_r.chip_en_n && pins_r.data_oe))
		else $error("write strobe low without chip enable or with output enable");
	a_we_width: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$fell(pins_r.write_en_n) |-> !pins_r.write_en_n [*3])
		else $error("write strobe pulse too short");
	a_data_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		$rose(pins_r.write_en_n) |-> pins_r.data_oe && $stable(pins_r.data_out)
		&& pins_r.data_out == cyc_r.data && pins_r.word_address_in == cyc_r.addr)
		else $error("data not held at write strobe rise");
endmodule : prom_write_cycle

// ---- verilog/prom_host.sv ----
// Purpose: host controller issuing read and command sequences to the rewriteable prom
// Assumes: pin inputs from the prom are asynchronous; user side on clk_sys_i
// Notes:   one operation at a time; busy_o stays high until the internal timer expires
`timescale 1ns/1ps
`include "prom_host_regs.svh"
module prom_host
	import prom_host_pkg::*;
#(
	parameter int ERASE_CYCLES   = `ERASE_CYC,
	parameter int PROGRAM_CYCLES = `WORD_PROGRAM_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic        req_i,
	input  wire op_t         op_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	output logic             busy_o,
	output logic             done_o,
	output logic [15:0]      rdata_o,
	output logic             chip_en_n_o,
	output logic             out_en_n_o,
	output logic             write_en_n_o,
	output logic [15:0]      word_address_in_o,
	output logic [15:0]      data_bus_o,
	output logic             data_bus_oe_o,
	input  wire logic [15:0] data_bus_i
);
	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_READ  = 6'b000010,
		S_WRITE = 6'b000100,
		S_WWAIT = 6'b001000,
		S_TIMED = 6'b010000,
		S_DONE  = 6'b100000
	} host_state_t;

	localparam logic [4:0]  READ_CNT = 5'(`READ_CYC);
	localparam logic [31:0] ERASE_CNT = 32'(ERASE_CYCLES);
	localparam logic [31:0] PROG_CNT  = 32'(PROGRAM_CYCLES);

	host_state_t state_r, state_nxt;
	op_t         op_r, op_nxt;
	logic [2:0]  step_r, step_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic        done_r, done_nxt;
	logic        busy_r, busy_nxt;
	logic        rd_pins_r, rd_pins_nxt;
	logic [15:0] sync1_r, sync2_r;
	logic        wc_start;
	logic        wc_busy;
	logic        wc_done;
	bus_cycle_t  wc_cycle;
	pin_bus_t    wc_pins;
	pin_bus_t    pins_r, pins_nxt;

	// command table: address and byte of each step, high byte don't care
	function automatic bus_cycle_t step_cycle(input op_t op, input logic [2:0] step,
		input logic [15:0] a, input logic [15:0] d);
		bus_cycle_t c;
		c = '{addr: `UNLOCK_ADDR_A, data: {8'h00, `UNLOCK_DATA_A}};
		if (op == OP_ID_EXIT) begin
			c = '{addr: a, data: {8'h00, `CMD_ID_EXIT}};
		end else begin
			unique case (step)
				3'd0: c = '{addr: `UNLOCK_ADDR_A, data: {8'h00, `UNLOCK_DATA_A}};
				3'd1: c = '{addr: `UNLOCK_ADDR_B, data: {8'h00, `UNLOCK_DATA_B}};
				3'd2: begin
					unique case (op)
						OP_ERASE:   c.data = {8'h00, `CMD_ERASE_SETUP};
						OP_PROGRAM: c.data = {8'h00, `CMD_PROGRAM_SETUP};
						default:    c.data = {8'h00, `CMD_ID_ENTRY};
					endcase
					c.addr = `UNLOCK_ADDR_A;
				end
				3'd3: begin
					if (op == OP_PROGRAM) c = '{addr: a, data: d};
					else c = '{addr: `UNLOCK_ADDR_A, data: {8'h00, `UNLOCK_DATA_A}};
				end
				3'd4: c = '{addr: `UNLOCK_ADDR_B, data: {8'h00, `UNLOCK_DATA_B}};
				default: c = '{addr: `UNLOCK_ADDR_A, data: {8'h00, `CMD_ERASE_CONFIRM}};
			endcase
		end
		return c;
	endfunction : step_cycle

	function automatic logic [2:0] last_step(input op_t op);
		unique case (op)
			OP_ERASE:    return 3'd5;
			OP_PROGRAM:  return 3'd3;
			OP_ID_ENTRY: return 3'd2;
			default:     return 3'd0;
		endcase
	endfunction : last_step

	prom_write_cycle u_write (
		.clk_sys_i (clk_sys_i),
		.reset_n_i (reset_n_i),
		.start_i   (wc_start),
		.cycle_i   (wc_cycle),
		.busy_o    (wc_busy),
		.done_o    (wc_done),
		.pins_o    (wc_pins)
	);

	assign wc_start = (state_r == S_WRITE);
	assign wc_cycle = step_cycle(op_r, step_r, addr_r, wdata_r);

	always_comb begin
		state_nxt   = state_r;
		op_nxt      = op_r;
		step_nxt    = step_r;
		cnt_nxt     = cnt_r;
		addr_nxt    = addr_r;
		wdata_nxt   = wdata_r;
		rdata_nxt   = rdata_r;
		done_nxt    = 1'b0;
		rd_pins_nxt = rd_pins_r;
		unique case (state_r)
			S_IDLE: begin
				// new requests only when nothing is timing inside the device
				if (req_i) begin
					op_nxt    = op_i;
					addr_nxt  = addr_i;
					wdata_nxt = wdata_i;
					step_nxt  = 3'd0;
					if (op_i == OP_READ) begin
						rd_pins_nxt = 1'b1;
						cnt_nxt     = 32'(READ_CNT) + 32'd2;
						state_nxt   = S_READ;
					end else begin
						state_nxt = S_WRITE;
					end
				end
			end
			S_READ: begin
				cnt_nxt = cnt_r - 32'd1;
				if (cnt_r == 32'd1) begin
					rdata_nxt   = sync2_r;
					rd_pins_nxt = 1'b0;
					state_nxt   = S_DONE;
				end
			end
			S_WRITE: state_nxt = S_WWAIT;
			S_WWAIT: begin
				if (wc_done) begin
					if (step_r == last_step(op_r)) begin
						// erase timer starts only after the final strobe rise
						unique case (op_r)
							OP_ERASE:   cnt_nxt = ERASE_CNT;
							OP_PROGRAM: cnt_nxt = PROG_CNT;
							default:    cnt_nxt = 32'd1;
						endcase
						state_nxt = S_TIMED;
					end else begin
						step_nxt  = step_r + 3'd1;
						state_nxt = S_WRITE;
					end
				end
			end
			S_TIMED: begin
				cnt_nxt = cnt_r - 32'd1;
				if (cnt_r <= 32'd1) state_nxt = S_DONE;
			end
			S_DONE: begin
				done_nxt  = 1'b1;
				state_nxt = S_IDLE;
			end
			default: state_nxt = S_IDLE;
		endcase
		busy_nxt = (state_nxt != S_IDLE);
	end

	always_comb begin
		pins_nxt = wc_pins;
		if (rd_pins_nxt) begin
			pins_nxt.chip_en_n       = 1'b0;
			pins_nxt.out_en_n        = 1'b0;
			pins_nxt.write_en_n      = 1'b1;
			pins_nxt.word_address_in = addr_nxt;
			pins_nxt.data_oe         = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_r   <= S_IDLE;
			op_r      <= OP_READ;
			step_r    <= 3'd0;
			cnt_r     <= 32'd0;
			addr_r    <= 16'h0000;
			wdata_r   <= 16'h0000;
			rdata_r   <= 16'h0000;
			done_r    <= 1'b0;
			busy_r    <= 1'b0;
			rd_pins_r <= 1'b0;
			sync1_r   <= 16'h0000;
			sync2_r   <= 16'h0000;
			pins_r    <= '{chip_en_n: 1'b1, out_en_n: 1'b1, write_en_n: 1'b1,
				word_address_in: 16'h0000, data_out: 16'h0000, data_oe: 1'b0};
		end else begin
			state_r   <= state_nxt;
			op_r      <= op_nxt;
			step_r    <= step_nxt;
			cnt_r     <= cnt_nxt;
			addr_r    <= addr_nxt;
			wdata_r   <= wdata_nxt;
			rdata_r   <= rdata_nxt;
			done_r    <= done_nxt;
			busy_r    <= busy_nxt;
			rd_pins_r <= rd_pins_nxt;
			sync1_r   <= data_bus_i;
			sync2_r   <= sync1_r;
			pins_r    <= pins_nxt;
		end
	end

	assign busy_o            = busy_r;
	assign done_o            = done_r;
	assign rdata_o           = rdata_r;
	assign chip_en_n_o       = pins_r.chip_en_n;
	assign out_en_n_o        = pins_r.out_en_n;
	assign write_en_n_o      = pins_r.write_en_n;
	assign word_address_in_o = pins_r.word_address_in;
	assign data_bus_o        = pins_r.data_out;
	assign data_bus_oe_o     = pins_r.data_oe;

	a_no_contention: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		data_bus_oe_o |-> out_en_n_o)
		else $error("host drives bus while output enable low");
	a_wr_oe_high: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		!write_en_n_o |-> out_en_n_o && !chip_en_n_o)
		else $error("write strobe with bad enables");
	a_read_pins: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_r == S_READ) |-> (!chip_en_n_o && !out_en_n_o && write_en_n_o && !data_bus_oe_o))
		else $error("read without proper enables");
	a_timed_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_r == S_TIMED) |-> write_en_n_o && busy_o)
		else $error("strobe during internal operation");
	a_erase_last: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(wc_start && op_r == OP_ERASE && step_r == 3'd5) |->
		wc_cycle.addr == 16'h5555 && wc_cycle.data[7:0] == 8'h10)
		else $error("bad final erase cycle");
	a_unlock_two: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(wc_start && op_r != OP_ID_EXIT && step_r == 3'd1) |->
		wc_cycle.addr == 16'h2aaa && wc_cycle.data[7:0] == 8'h55)
		else $error("bad second unlock cycle");
	a_done_pulse: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		done_o |-> !busy_o ##1 !done_o)
		else $error("done not a single pulse");
	a_prog_wait: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		(state_r == S_WWAIT && wc_done && op_r == OP_PROGRAM && step_r == 3'd3) |=>
		state_r == S_TIMED && cnt_r == PROG_CNT)
		else $error("program wait not started");
	a_wc_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
		wc_start |-> !wc_busy)
		else $error("write cycle started while one is running");

	c_read: cover property (@(posedge clk_sys_i) state_r == S_READ ##1 state_r == S_DONE);
	c_erase: cover property (@(posedge clk_sys_i) state_r == S_TIMED && op_r == OP_ERASE);
	c_prog: cover property (@(posedge clk_sys_i) state_r == S_TIMED && op_r == OP_PROGRAM);
	c_idexit: cover property (@(posedge clk_sys_i) done_o && op_r == OP_ID_EXIT);
endmodule : prom_host

// ---- test/prom_device_model.sv ----
// Purpose: behavioural model of the rewriteable prom on the far side of the host
// Assumes: host strobes write with write enable as the last falling and first rising strobe
// Notes:   only write-enable controlled writes are decoded; id code values are arbitrary
`timescale 1ns/1ps
module prom_device_model #(
	parameter logic [15:0] MFR_CODE   = 16'h1234, // arbitrary value
	parameter logic [15:0] DEV_CODE   = 16'h5678, // arbitrary value
	parameter int          ERASE_NS   = 200,
	parameter int          PROGRAM_NS = 100,
	parameter int          FILTER_NS  = 15
) (
	input  wire logic        chip_en_n_i,
	input  wire logic        out_en_n_i,
	input  wire logic        write_en_n_i,
	input  wire logic [15:0] word_address_in_i,
	input  wire logic [15:0] data_bus_i,
	input  wire logic        vcc_low_i,
	output logic [15:0]      data_bus_o,
	output logic             data_bus_drive_o
);
	logic [15:0] mem [0:65535];
	logic [15:0] lat_addr;
	logic [15:0] prog_addr;
	logic [15:0] prog_data;
	logic [7:0]  cmd;
	int          step;
	bit          id_mode;
	bit          busy;
	realtime     fall_t;
	event        erase_ev;
	event        prog_ev;

	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		step = 0;
		id_mode = 0;
		busy = 0;
		fall_t = 0;
	end

	// address captured on the falling strobe
	always @(negedge write_en_n_i) begin
		if (chip_en_n_i === 1'b0) begin
			lat_addr = word_address_in_i;
			fall_t = $realtime;
		end
	end

	// data captured on the rising strobe; inhibit, glitch filter and busy lockout
	always @(posedge write_en_n_i) begin
		if (chip_en_n_i === 1'b0 && out_en_n_i === 1'b1 && !busy && ($realtime - fall_t) >= FILTER_NS) begin
			cmd = data_bus_i[7:0];
			case (step)
				0: begin
					if (cmd == 8'hf0) id_mode = 0;
					step = (lat_addr == 16'h5555 && cmd == 8'haa) ? 1 : 0;
				end
				1: step = (lat_addr == 16'h2aaa && cmd == 8'h55) ? 2 : 0;
				2: begin
					step = 0;
					if (lat_addr == 16'h5555 && cmd == 8'h80) step = 3;
					if (lat_addr == 16'h5555 && cmd == 8'ha0) step = 6;
					if (lat_addr == 16'h5555 && cmd == 8'h90) id_mode = 1;
				end
				3: step = (lat_addr == 16'h5555 && cmd == 8'haa) ? 4 : 0;
				4: step = (lat_addr == 16'h2aaa && cmd == 8'h55) ? 5 : 0;
				5: begin
					step = 0;
					if (lat_addr == 16'h5555 && cmd == 8'h10) ->erase_ev;
				end
				default: begin
					step = 0;
					prog_addr = lat_addr;
					prog_data = data_bus_i;
					if (!vcc_low_i) ->prog_ev;
				end
			endcase
		end
	end

	always begin
		@(erase_ev);
		busy = 1;
		#(ERASE_NS);
		foreach (mem[i]) mem[i] = 16'hffff;
		busy = 0;
	end

	always begin
		@(prog_ev);
		busy = 1;
		#(PROGRAM_NS);
		mem[prog_addr] = mem[prog_addr] & prog_data;
		busy = 0;
	end

	assign data_bus_drive_o = !chip_en_n_i && !out_en_n_i && write_en_n_i;
	assign data_bus_o = (id_mode && word_address_in_i[15:1] == 15'h0000) ?
		(word_address_in_i[0] ? DEV_CODE : MFR_CODE) : mem[word_address_in_i];
endmodule : prom_device_model

// ---- test/prom_host_tb_top.sv ----
// Purpose: self-checking bench for the prom host controller against a device model
// Assumes: shortened erase and program timers
// Notes:   expected words are tracked in a shadow map of programmed addresses
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module prom_host_tb_top;
	import prom_host_pkg::*;
	localparam logic [15:0] MFR = 16'h1234; // arbitrary value
	localparam logic [15:0] DEV = 16'h5678; // arbitrary value
	logic        clk_sys_i = 0;
	logic        reset_n_i = 0;
	logic        req_i = 0;
	op_t         op_i = OP_READ;
	logic [15:0] addr_i = 0;
	logic [15:0] wdata_i = 0;
	logic        vcc_low = 0;
	logic        busy_o, done_o, chip_en_n_o, out_en_n_o, write_en_n_o, data_bus_oe_o, dev_drive;
	logic [15:0] rdata_o, word_address_in_o, data_bus_o, dev_data, data_bus, prev_bus;
	logic [31:0] seed = 32'h2325;
	int          err_total = 0;
	int          checked = 0;
	bus_cycle_t  wr_q[$];
	bus_cycle_t  exp_q[$];
	logic [15:0] shadow [logic [15:0]];
	logic [15:0] a, d;

	always #10 clk_sys_i = ~clk_sys_i;

	prom_host #(.ERASE_CYCLES(20), .PROGRAM_CYCLES(10)) i_prom_host (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .req_i(req_i), .op_i(op_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o),
		.chip_en_n_o(chip_en_n_o), .out_en_n_o(out_en_n_o), .write_en_n_o(write_en_n_o),
		.word_address_in_o(word_address_in_o), .data_bus_o(data_bus_o),
		.data_bus_oe_o(data_bus_oe_o), .data_bus_i(data_bus));

	prom_device_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_prom_device_model (
		.chip_en_n_i(chip_en_n_o), .out_en_n_i(out_en_n_o), .write_en_n_i(write_en_n_o),
		.word_address_in_i(word_address_in_o), .data_bus_i(data_bus), .vcc_low_i(vcc_low),
		.data_bus_o(dev_data), .data_bus_drive_o(dev_drive));

	// an undriven bus shows a pattern that flips every cycle
	always @(posedge clk_sys_i) prev_bus <= data_bus;
	assign data_bus = data_bus_oe_o ? data_bus_o : (dev_drive ? dev_data : ~prev_bus);

	always @(negedge write_en_n_o) begin
		if (reset_n_i === 1'b1) begin
			`CHK("oe_during_write", 1'b1, out_en_n_o)
			`CHK("ce_during_write", 1'b0, chip_en_n_o)
		end
	end
	always @(posedge write_en_n_o) begin
		if (reset_n_i === 1'b1) begin
			`CHK("host_drives_data", 1'b1, data_bus_oe_o)
			wr_q.push_back({word_address_in_o, data_bus_o});
		end
	end

	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [15:0] exp_word(logic [15:0] x);
		return shadow.exists(x) ? shadow[x] : 16'hffff;
	endfunction : exp_word

	function automatic void build(op_t op, logic [15:0] x, logic [15:0] y);
		exp_q = {};
		if (op inside {OP_ERASE, OP_PROGRAM, OP_ID_ENTRY}) begin
			exp_q.push_back({16'h5555, 16'h00aa});
			exp_q.push_back({16'h2aaa, 16'h0055});
			exp_q.push_back({16'h5555, (op == OP_ERASE) ? 16'h0080 : (op == OP_PROGRAM) ? 16'h00a0 : 16'h0090});
		end
		if (op == OP_ERASE) begin
			exp_q.push_back({16'h5555, 16'h00aa});
			exp_q.push_back({16'h2aaa, 16'h0055});
			exp_q.push_back({16'h5555, 16'h0010});
		end
		if (op == OP_PROGRAM) exp_q.push_back({x, y});
		if (op == OP_ID_EXIT) exp_q.push_back({x, 16'h00f0});
	endfunction : build

	task automatic do_op(op_t op, logic [15:0] x, logic [15:0] y, bit poke);
		int n;
		@(posedge clk_sys_i) #1;
		op_i = op;
		addr_i = x;
		wdata_i = y;
		req_i = 1;
		@(posedge clk_sys_i) #1;
		`CHK("busy", 1'b1, busy_o)
		if (poke) begin
			// keep the request up one more edge while busy: it must be ignored
			op_i = OP_ERASE;
			@(posedge clk_sys_i) #1;
		end
		req_i = 0;
		n = 0;
		while (done_o !== 1'b1 && n < 2000) begin
			@(posedge clk_sys_i) #1;
			n++;
		end
		if (n >= 2000) `CHK("done", 1'b1, done_o)
		build(op, x, y);
		`CHK("write_count", exp_q.size(), wr_q.size())
		foreach (exp_q[i]) if (i < wr_q.size()) `CHK("write_cycle", exp_q[i], wr_q[i])
		wr_q = {};
	endtask : do_op

	task automatic rd_chk(logic [15:0] x, logic [15:0] e);
		do_op(OP_READ, x, 16'h0000, 0);
		`CHK("rdata", e, rdata_o)
	endtask : rd_chk

	task automatic prog(logic [15:0] x, logic [15:0] y, bit poke);
		do_op(OP_PROGRAM, x, y, poke);
		shadow[x] = exp_word(x) & y;
		rd_chk(x, exp_word(x));
	endtask : prog

	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	initial begin
		// about nine times the length of the full run
		#(20 * 20000);
		err_total++;
		finish_test;
	end

	initial begin
		repeat (10) @(posedge clk_sys_i);
		#1;
		`CHK("ce_idle", 1'b1, chip_en_n_o)
		`CHK("we_idle", 1'b1, write_en_n_o)
		`CHK("oe_idle", 1'b0, data_bus_oe_o)
		reset_n_i = 1;
		rd_chk(16'h0000, 16'h0000);
		do_op(OP_ERASE, 16'h0000, 16'h0000, 0);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			rd_chk(seed[15:0], 16'hffff);
		end
		prog(16'h0000, 16'hf0f0, 1);
		prog(16'h0000, 16'h3c3c, 0);
		prog(16'hffff, 16'hffff, 0);
		prog(16'hffff, 16'h0000, 0);
		prog(16'h5555, 16'h00aa, 0);
		prog(16'h2aaa, 16'h0055, 0);
		for (int i = 0; i < 20; i++) begin
			seed = lfsr(seed);
			a = seed[15:0];
			seed = lfsr(seed);
			d = seed[15:0];
			prog(a, d, 0);
		end
		do_op(OP_ID_ENTRY, 16'h0000, 16'h0000, 0);
		rd_chk(16'h0000, MFR);
		rd_chk(16'h0001, DEV);
		rd_chk(16'h0002, exp_word(16'h0002));
		do_op(OP_ID_EXIT, 16'h1234, 16'h0000, 0);
		rd_chk(16'h0000, exp_word(16'h0000));
		vcc_low = 1;
		do_op(OP_PROGRAM, 16'h0100, 16'h0000, 0);
		vcc_low = 0;
		rd_chk(16'h0100, exp_word(16'h0100));
		do_op(OP_ERASE, 16'h0000, 16'h0000, 0);
		shadow.delete();
		rd_chk(16'h0000, 16'hffff);
		prog(16'h0000, 16'ha5a5, 0);
		finish_test;
	end
endmodule : prom_host_tb_top
